// [input_pin_router.sv]
// Purpose: Routes port pins to digital peripheral inputs by per-input selectors
// Assumes: Register port with one-cycle strobes; pins sampled on ref_clk
// Notes:   Output routing lives elsewhere and shares no state with this block
//
// Contract
// - Only digital pins routed, analog untouched
// - Input routing independent of output routing
// - One selector register per routed input
// - One pin may feed many inputs
// - Port reads return actual pin levels; here analog-selected pins read 0
// - Six-bit code: port in top, pin low
// - Inputs connect only from permitted ports
// - Selectors load default pin at reset
// - Serial pins report bus-level capability per pin
// - Lock toggled only after 55h, AAh sequence
// - One-way setting keeps lock until reset
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "pin_router_map.svh"

module input_pin_router
  import pin_router_pkg::*;
#(
  parameter int                                NUM_INPUTS    = `NUM_ROUTED,
  parameter int                                NUM_PINS      = `NUM_PINS,
  parameter logic [NUM_INPUTS*`CODE_W-1:0]     DEFAULT_CODES = `DEFAULT_CODES,
  parameter logic [NUM_INPUTS*3-1:0]           PERMIT_MASKS  = `PERMIT_MASKS,
  parameter logic [NUM_PINS-1:0]               BUS_PIN_MASK  = `BUS_PIN_MASK
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [`ADDR_W-1:0]    addr,
  input  wire logic [`DATA_W-1:0]    wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic      [`DATA_W-1:0]    rdata,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  input  wire logic [NUM_PINS-1:0]   analog_select,
  input  wire logic                  one_way_lock_setting,
  output logic      [NUM_INPUTS-1:0] routed_in,
  output logic      [NUM_INPUTS-1:0] bus_level,
  output logic                       routing_locked_bit
);

  typedef struct packed {
    logic [NUM_INPUTS-1:0][`CODE_W-1:0] sel;
    logic                               locked;
    lock_seq_t                          seq;
    logic [`DATA_W-1:0]                 rdata;
    logic [NUM_INPUTS-1:0]              routed;
    logic [NUM_INPUTS-1:0]              bus_lvl;
  } router_state_t;

  router_state_t q;
  router_state_t d;

  logic [NUM_PINS-1:0]                pin_sync_lvl;
  logic [NUM_PINS-1:0]                pin_lvl;
  logic                               sel_in_range;
  logic                               sel_we;
  logic [`ADDR_W-1:0]                 sel_offset;
  logic [NUM_INPUTS-1:0][`CODE_W-1:0] sel_next;
  logic [NUM_INPUTS-1:0]              route_bit;
  logic [NUM_INPUTS-1:0]              bus_bit;
  logic [`DATA_W-1:0]                 read_value;

  // Pin levels into the clock domain
  pin_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_sync_lvl)
  );

  // Analog-selected pins have their digital buffer off and read low
  assign pin_lvl = pin_sync_lvl & ~analog_select;

  // Selector write decode; locked selectors ignore writes
  assign sel_in_range = ({24'h0, addr} >= {24'h0, `SEL_BASE_ADDR})
                      && (({24'h0, addr} - {24'h0, `SEL_BASE_ADDR}) < 32'(NUM_INPUTS));
  assign sel_we       = wr_stb && sel_in_range && !q.locked;

  // Selector index relative to the first selector address
  assign sel_offset   = addr - `SEL_BASE_ADDR;

  // Per-input selector and route
  for (genvar gi = 0; gi < NUM_INPUTS; gi++) begin : g_route
    logic [`CODE_W-1:0] code;
    logic [2:0]         permit;
    logic [1:0]         port_sel;
    logic               code_ok;
    logic               hit;

    // Write strobe aimed at this input's selector
    assign hit = sel_we && (sel_offset == `ADDR_W'(gi));

    // Next code: the written value for this input, else the held one
    always_comb begin
      if (hit) begin
        sel_next[gi] = wdata[`CODE_W-1:0];
      end else begin
        sel_next[gi] = q.sel[gi];
      end
    end

    assign code     = sel_next[gi];
    assign permit   = PERMIT_MASKS[gi*3 +: 3];
    assign port_sel = code[4:3];

    // Only codes on the first three ports within this input's mask connect
    assign code_ok  = !code[5] && (port_sel != `PORT_NONE) && permit[port_sel];

    // Each input reads its pin independently, so shared pins fan out
    assign route_bit[gi] = code_ok ? pin_lvl[code[4:0]] : 1'b0;
    assign bus_bit[gi]   = code_ok ? BUS_PIN_MASK[code[4:0]] : 1'b0;
  end

  // Register read mux
  always_comb begin
    read_value = '0;
    if (sel_in_range) begin
      read_value[`CODE_W-1:0] = q.sel[6'(sel_offset)];
    end else begin
      case (addr)
        `LOCK_ADDR: begin
          read_value[`LOCK_BIT] = q.locked;
        end
        `PORT_A_ADDR: begin
          read_value = pin_lvl[0*`PORT_W +: `PORT_W];
        end
        `PORT_B_ADDR: begin
          read_value = pin_lvl[1*`PORT_W +: `PORT_W];
        end
        `PORT_C_ADDR: begin
          read_value = pin_lvl[2*`PORT_W +: `PORT_W];
        end
        `PORT_E_ADDR: begin
          read_value[`PORT_E_BIT] = pin_lvl[`PORT_E_PIN];
        end
        default: begin
          read_value = '0;
        end
      endcase
    end
  end

  // Next state
  always_comb begin
    d       = q;
    d.rdata = '0;

    if (wr_stb) begin
      if (addr == `LOCK_ADDR) begin
        case (q.seq)
          SEQ_IDLE: begin
            d.seq = (wdata == `UNLOCK_KEY_1) ? SEQ_GOT_FIRST : SEQ_IDLE;
          end
          SEQ_GOT_FIRST: begin
            if (wdata == `UNLOCK_KEY_2) begin
              d.seq = SEQ_ARMED;
            end else if (wdata == `UNLOCK_KEY_1) begin
              d.seq = SEQ_GOT_FIRST;
            end else begin
              d.seq = SEQ_IDLE;
            end
          end
          SEQ_ARMED: begin
            if (wdata[`LOCK_BIT]) begin
              d.locked = 1'b1;
            end else if (!(one_way_lock_setting && q.locked)) begin
              d.locked = 1'b0;
            end
            d.seq = SEQ_IDLE;
          end
          default: begin
            d.seq = SEQ_IDLE;
          end
        endcase
      end else begin
        // Any other write breaks the unlock sequence
        d.seq = SEQ_IDLE;
      end
    end

    d.sel     = sel_next;
    d.routed  = route_bit;
    d.bus_lvl = bus_bit;

    if (rd_stb) begin
      d.rdata = read_value;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q.sel     <= DEFAULT_CODES;
      q.locked  <= 1'b0;
      q.seq     <= SEQ_IDLE;
      q.rdata   <= '0;
      q.routed  <= '0;
      q.bus_lvl <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops; no analog path is switched here
  assign rdata              = q.rdata;
  assign routed_in          = q.routed;
  assign bus_level          = q.bus_lvl;
  assign routing_locked_bit = q.locked;

endmodule : input_pin_router

`default_nettype wire

// [input_pin_router_assertions.sv]
// Purpose: Port checks of the router
// Assumes: Synchronous active-high reset
// Notes:   Lock keys sent back to back
`timescale 1ns/1ps
`default_nettype none
module input_pin_router_assertions #(
  parameter int NUM_INPUTS = 41,
  parameter int NUM_PINS   = 25
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic [7:0]            addr,
  input wire logic [7:0]            wdata,
  input wire logic                  wr_stb,
  input wire logic                  rd_stb,
  input wire logic [7:0]            rdata,
  input wire logic [NUM_PINS-1:0]   pin_in,
  input wire logic [NUM_PINS-1:0]   analog_select,
  input wire logic                  one_way_lock_setting,
  input wire logic [NUM_INPUTS-1:0] routed_in,
  input wire logic [NUM_INPUTS-1:0] bus_level,
  input wire logic                  routing_locked_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata idle");
  AST_SEL_TOP: assert property ($past(rd_stb && addr <= 8'h28) |-> rdata[7:6] == 2'h0) else $error("code");
  AST_UNMAP: assert property ($past(rd_stb && (addr > 8'h34 || (addr > 8'h28 && addr < 8'h30)))
    |-> rdata == 8'h00) else $error("unmapped");
  AST_LK_RD: assert property ($past(rd_stb && addr == 8'h30) |-> rdata == {7'h00, $past(routing_locked_bit)})
    else $error("lock read");
  AST_LK_HOLD: assert property (!$past(wr_stb && addr == 8'h30) |-> $stable(routing_locked_bit))
    else $error("lock moved");
  AST_LK_KEY: assert property ($changed(routing_locked_bit) |-> $past(wdata, 2) == 8'hAA
    && $past(wdata, 3) == 8'h55 && $past(wdata[0]) == routing_locked_bit) else $error("lock key");
  AST_ONE_WAY: assert property (one_way_lock_setting && routing_locked_bit |=> routing_locked_bit)
    else $error("one way");
  AST_ANALOG: assert property ((&analog_select)[*5] |=> routed_in == '0) else $error("analog");
  AST_PINS_LOW: assert property ((pin_in == '0)[*4] |=> routed_in == '0) else $error("pins low");
  COV_LOCK: cover property ($rose(routing_locked_bit));
  COV_SEL_WR: cover property (wr_stb && addr <= 8'h28);
  COV_PORT_RD: cover property (rd_stb && addr == 8'h31);
endmodule : input_pin_router_assertions
bind input_pin_router input_pin_router_assertions #(.NUM_INPUTS(NUM_INPUTS), .NUM_PINS(NUM_PINS)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .pin_in(pin_in), .analog_select(analog_select), .one_way_lock_setting(one_way_lock_setting),
  .routed_in(routed_in), .bus_level(bus_level), .routing_locked_bit(routing_locked_bit));
`default_nettype wire

// [peripheral_input_pin_router_tb_top.sv]
// Purpose: Bench for the router
// Assumes: Pins come from pin_level_model
// Notes:   Random codes include illegal ones
`timescale 1ns/1ps
`default_nettype none
`include "pin_router_map.svh"
module peripheral_input_pin_router_tb_top;
  localparam logic [245:0] DC = `DEFAULT_CODES;
  localparam logic [122:0] PM = `PERMIT_MASKS;
  localparam logic [24:0]  BM = `BUS_PIN_MASK;
  logic        ref_clk = 1'h0, rst = 1'h1, wr_stb = 1'h0, rd_stb = 1'h0, ow = 1'h0, lk = 1'h0, locked;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, got;
  logic [24:0] pin_req = '0, ana = '0, pin_in;
  logic [40:0] routed_in, bus_level, er, eb;
  logic [5:0]  sel [41];
  int          errors = 0, checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  pin_level_model i_pin_level_model (.ref_clk(ref_clk), .pin_req(pin_req), .pin_in(pin_in));
  input_pin_router i_input_pin_router (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .analog_select(ana),
    .one_way_lock_setting(ow), .routed_in(routed_in), .bus_level(bus_level), .routing_locked_bit(locked));
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic exp_ok(int i, logic [5:0] c);
    return !c[5] && c[4:3] != 2'h3 && PM[i*3+c[4:3]];
  endfunction : exp_ok
  task automatic cyc(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    {wr_stb, rd_stb, addr, wdata} <= {w, r, a, d};
    if (w && a <= 8'h28 && !lk) sel[a] = d[5:0];
  endtask : cyc
  task automatic rd(logic [7:0] a);
    cyc(1'h0, 1'h1, a, 8'h00);
    cyc(1'h0, 1'h0, a, 8'h00);
    #1 got = rdata;
  endtask : rd
  task automatic key(logic v);
    cyc(1'h1, 1'h0, 8'h30, 8'h55);
    cyc(1'h1, 1'h0, 8'h30, 8'hAA);
    cyc(1'h1, 1'h0, 8'h30, {7'h00, v});
    if (!(ow && lk)) lk = v;
    cyc(1'h0, 1'h0, 8'h00, 8'h00);
    #1 check("lock", locked, lk);
    rd(8'h30);
    check("lock reg", got, {7'h00, lk});
  endtask : key
  task automatic route(int n);
    logic [5:0] c;
    repeat (n) cyc(1'h0, 1'h0, 8'h00, 8'h00);
    for (int i = 0; i < 41; i++) begin
      c = sel[i];
      er[i] = 1'h0;
      eb[i] = 1'h0;
      if (exp_ok(i, c)) begin
        er[i] = pin_req[c[4:0]] & ~ana[c[4:0]];
        eb[i] = BM[c[4:0]];
      end
    end
    #1 check("routed_in", routed_in, er);
    check("bus_level", bus_level, eb);
    for (int p = 0; p < 4; p++) begin
      rd(8'h31 + p[7:0]);
      check("port", got, p < 3 ? 8'((pin_req & ~ana) >> (8 * p)) : {4'h0, pin_req[24] & ~ana[24], 3'h0});
    end
  endtask : route
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(57));
    for (int i = 0; i < 41; i++) sel[i] = DC[i*6+:6];
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    for (int i = 0; i < 42; i++) begin
      rd(i[7:0]);
      check("sel", got, i < 41 ? {2'h0, sel[i]} : 8'h00);
    end
    $display("test defaults done");
    repeat (30) begin
      @(posedge ref_clk);
      pin_req <= 25'($urandom);
      repeat (4) cyc(1'h0, 1'h0, 8'h00, 8'h00);
      cyc(1'h1, 1'h0, 8'($urandom_range(40)), 8'($urandom));
      cyc(1'h1, 1'h0, 8'($urandom_range(40)), 8'($urandom));
      route(1);
    end
    for (int i = 0; i < 41; i++) cyc(1'h1, 1'h0, i[7:0], 8'h08);
    route(1);
    @(posedge ref_clk);
    ana <= '1;
    route(5);
    @(posedge ref_clk);
    ana <= '0;
    route(1);
    $display("test routing done");
    key(1'h1);
    cyc(1'h1, 1'h0, 8'h00, 8'h01);
    rd(8'h00);
    check("locked sel", got, {2'h0, sel[0]});
    @(posedge ref_clk);
    ow <= 1'h1;
    key(1'h0);
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (6) @(posedge ref_clk);
    {rst, ow, lk} <= 3'h0;
    for (int i = 0; i < 41; i++) sel[i] = DC[i*6+:6];
    route(4);
    key(1'h1);
    key(1'h0);
    $display("test lock done");
    report_and_stop();
  end
endmodule : peripheral_input_pin_router_tb_top
`default_nettype wire

// [pin_level_model.sv]
// Purpose: Far-side pin levels
// Assumes: Bench requests levels
// Notes:   Pins move just after an edge
`timescale 1ns/1ps
`default_nettype none
module pin_level_model (
  input  wire logic        ref_clk,
  input  wire logic [24:0] pin_req,
  output logic      [24:0] pin_in
);
  initial begin
    pin_in = '0;
    forever @(posedge ref_clk) pin_in <= pin_req;
  end
endmodule : pin_level_model
`default_nettype wire

// [pin_router_map.svh]
// Purpose: Constants for the peripheral input pin router
// Assumes: 6-bit pin codes, 8-bit register port
// Notes:   Default vectors hold entry 0 in the low bits
`ifndef PIN_ROUTER_MAP_SVH
`define PIN_ROUTER_MAP_SVH

`define NUM_ROUTED      41
`define NUM_PINS        25
`define CODE_W          6
`define ADDR_W          8
`define DATA_W          8

// Register indices on the register port
`define SEL_BASE_ADDR   8'h00
`define LOCK_ADDR       8'h30
`define PORT_A_ADDR     8'h31
`define PORT_B_ADDR     8'h32
`define PORT_C_ADDR     8'h33
`define PORT_E_ADDR     8'h34

// Lock register
`define UNLOCK_KEY_1    8'h55
`define UNLOCK_KEY_2    8'hAA
`define LOCK_BIT        0

// Pin code fields
`define PORT_E_CODE     6'h23
`define PORT_E_PIN      24
`define PORT_E_BIT      3
`define PORT_W          8
`define PORT_NONE       2'h3

// Permitted port mask per input: bit0 first port, bit1 second, bit2 third
`define PERMIT_AB       3'h3
`define PERMIT_AC       3'h5
`define PERMIT_BC       3'h6

// Power-on codes, entry 40 first
`define DEFAULT_CODES { \
  6'h0C, 6'h0D, 6'h10, 6'h11, 6'h0E, 6'h0F, 6'h16, 6'h17, 6'h08, 6'h08, \
  6'h09, 6'h05, 6'h14, 6'h13, 6'h0C, 6'h0F, 6'h0E, 6'h01, 6'h00, 6'h08, \
  6'h09, 6'h08, 6'h04, 6'h08, 6'h0D, 6'h11, 6'h12, 6'h05, 6'h04, 6'h01, \
  6'h0F, 6'h0C, 6'h12, 6'h15, 6'h10, 6'h10, 6'h13, 6'h0D, 6'h10, 6'h04, \
  6'h08 }

// Permitted ports, entry 40 first
`define PERMIT_MASKS { \
  `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, \
  `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_AC, \
  `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_AC, \
  `PERMIT_AC, `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_AC, `PERMIT_BC, \
  `PERMIT_BC, `PERMIT_BC, `PERMIT_BC, `PERMIT_AC, `PERMIT_AC, `PERMIT_AC, \
  `PERMIT_BC, `PERMIT_BC, `PERMIT_AC, `PERMIT_BC, `PERMIT_AC, `PERMIT_BC, \
  `PERMIT_AC, `PERMIT_BC, `PERMIT_AC, `PERMIT_AB, `PERMIT_AB }

// Pins with two-wire-bus input levels
`define BUS_PIN_MASK    25'h0180600

`endif

// [pin_router_pkg.sv]
// Purpose: Types for the peripheral input pin router
// Assumes: Used with pin_router_map.svh
// Notes:   Unlock sequence states
package pin_router_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE      = 2'b00,
    SEQ_GOT_FIRST = 2'b01,
    SEQ_ARMED     = 2'b10
  } lock_seq_t;

endpackage : pin_router_pkg

// [pin_sync.sv]
// Purpose: Two-stage synchroniser for pin levels
// Assumes: One clock, synchronous active-high reset
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 25
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d        = q;
    d.stage1 = async_in;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stage2;

endmodule : pin_sync

`default_nettype wire
